// ===== core/sgc_fault_check.sv
`timescale 1ns/1ps
`include "sgc_params.svh"
module sgc_fault_check (
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [2:0] unit_access, // Access strobes to each unit.
    input wire logic [2:0] unit_clk_en, // Current clock enables.
    output logic [2:0] unit_fault // One-cycle bus fault pulses.
);
    wire [2:0] nxt_unit_fault;

    // Each unit faults on its own; a stopped unit cannot answer a bus cycle.
    genvar gi;
    generate
        for (gi = 0; gi < `SGC_NUM_UNITS; gi++) begin : g_unit
            assign nxt_unit_fault[gi] = unit_access[gi] && !unit_clk_en[gi];
        end
    endgenerate

    // One register for all units keeps the output with a single writing process.
    always_ff @(posedge clk) begin
        if (rst) begin
            unit_fault <= 3'h0;
        end else begin
            unit_fault <= nxt_unit_fault;
        end
    end
endmodule

// ===== core/sgc_gate_select.sv
`timescale 1ns/1ps
`include "sgc_params.svh"
module sgc_gate_select (
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [31:0] run_gate, // Run-mode gating word.
    input wire logic [31:0] sleep_gate, // Sleep-mode gating word.
    input wire logic [31:0] deep_gate, // Deep-sleep gating word.
    input wire logic auto_gate, // Sleep words honoured when set.
    input wire logic [1:0] mode, // Current power mode.
    output logic [31:0] eff_gate // Registered effective gating word.
);
    logic [31:0] nxt_eff_gate;

    // Sleep words only act under automatic gating; otherwise run applies everywhere.
    always_comb begin
        nxt_eff_gate = run_gate;
        if (auto_gate && mode == sgc_pkg::SGC_MODE_SLEEP) begin
            nxt_eff_gate = sleep_gate;
        end else if (auto_gate && mode == sgc_pkg::SGC_MODE_DEEP) begin
            nxt_eff_gate = deep_gate;
        end
    end

    // Registering avoids glitches reaching the clock gates of the units.
    always_ff @(posedge clk) begin
        if (rst) begin
            eff_gate <= `SGC_GATE_RST;
        end else begin
            eff_gate <= nxt_eff_gate;
        end
    end

    property p_run_fallback;
        @(posedge clk) disable iff (rst)
        !auto_gate |=> eff_gate == $past(run_gate);
    endproperty
    a_run_fallback: assert property (p_run_fallback) else $error("Run word not applied.");
endmodule

// ===== core/sgc_top.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sgc_params.svh"
module sgc_top (
    input wire logic clk, // System clock, 20 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [31:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [31:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [1:0] power_mode, // Power mode, same clock domain.
    input wire logic [2:0] unit_access, // Access strobes: converter, hibernate, watchdog.
    output logic adc_clk_en, // Converter clock enable.
    output logic hib_clk_en, // Hibernation clock enable.
    output logic wdt_clk_en, // Watchdog clock enable.
    output logic [1:0] adc_rate_sel, // Converter sample rate code.
    output logic [2:0] unit_fault, // Bus fault pulses per unit.
    output logic irq // Level interrupt.
);
    logic aw_got_ff;
    logic w_got_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [31:0] raddr_ff;
    logic [31:0] run_gate_ff;
    logic [31:0] sleep_gate_ff;
    logic [31:0] deep_gate_ff;
    logic auto_gate_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    logic irq_ff;
    logic [31:0] eff_gate;
    logic [31:0] nxt_rdata;
    logic nxt_rhit;
    logic wr_fire;
    logic wr_hit;
    logic [2:0] unit_clk_en;

    // Full 32-bit match so aliases above the block do not hit.
    function automatic logic hit(input logic [31:0] a, input logic [11:0] ofs);
        hit = a[31:12] == 20'(`SGC_BASE >> 12) && a[11:0] == ofs;
    endfunction

    // Byte-lane merge; reserved bits are then masked off by the caller.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    // Address and data are taken independently, in either order.
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_hit = hit(awaddr_ff, `SGC_OFS_RUN_GATE) || hit(awaddr_ff, `SGC_OFS_SLEEP_GATE)
        || hit(awaddr_ff, `SGC_OFS_DEEP_GATE) || hit(awaddr_ff, `SGC_OFS_CLK_CFG)
        || hit(awaddr_ff, `SGC_OFS_IRQ_STAT) || hit(awaddr_ff, `SGC_OFS_IRQ_MASK)
        || hit(awaddr_ff, `SGC_OFS_EFF_GATE);

    // Write address capture.
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= 32'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got_ff <= 1'b0;
        end
    end

    // Write data capture.
    always_ff @(posedge clk) begin
        if (rst) begin
            w_got_ff <= 1'b0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got_ff <= 1'b0;
        end
    end

    // Write response; an unmapped address answers with a slave error.
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `SGC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? `SGC_RESP_OKAY : `SGC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Gating words; only the documented fields hold state.
    always_ff @(posedge clk) begin
        if (rst) begin
            run_gate_ff <= `SGC_GATE_RST;
            sleep_gate_ff <= `SGC_GATE_RST;
            deep_gate_ff <= `SGC_GATE_RST;
        end else if (wr_fire) begin
            if (hit(awaddr_ff, `SGC_OFS_RUN_GATE)) begin
                run_gate_ff <= merge(run_gate_ff, wdata_ff, wstrb_ff) & `SGC_GATE_WMASK;
            end
            if (hit(awaddr_ff, `SGC_OFS_SLEEP_GATE)) begin
                sleep_gate_ff <= merge(sleep_gate_ff, wdata_ff, wstrb_ff) & `SGC_GATE_WMASK;
            end
            if (hit(awaddr_ff, `SGC_OFS_DEEP_GATE)) begin
                deep_gate_ff <= merge(deep_gate_ff, wdata_ff, wstrb_ff) & `SGC_GATE_WMASK;
            end
        end
    end

    // Automatic gating select in the clock configuration word.
    always_ff @(posedge clk) begin
        if (rst) begin
            auto_gate_ff <= 1'(`SGC_CLK_CFG_RST >> `SGC_BIT_AUTO_GATE);
        end else if (wr_fire && hit(awaddr_ff, `SGC_OFS_CLK_CFG) && wstrb_ff[`SGC_BIT_AUTO_GATE / 8]) begin
            auto_gate_ff <= wdata_ff[`SGC_BIT_AUTO_GATE];
        end
    end

    // Sticky fault status; a fault in the clearing cycle still sets its bit.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_ff <= `SGC_IRQ_RST;
        end else if (wr_fire && hit(awaddr_ff, `SGC_OFS_IRQ_STAT) && wstrb_ff[0]) begin
            irq_stat_ff <= (irq_stat_ff & ~wdata_ff[2:0]) | unit_fault;
        end else begin
            irq_stat_ff <= irq_stat_ff | unit_fault;
        end
    end

    // Interrupt mask.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_ff <= `SGC_IRQ_RST;
        end else if (wr_fire && hit(awaddr_ff, `SGC_OFS_IRQ_MASK) && wstrb_ff[0]) begin
            irq_mask_ff <= wdata_ff[2:0];
        end
    end

    // Registered so the interrupt line never glitches on a status update.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end
    assign irq = irq_ff;

    // Read decode; reserved bits read as zero because they never hold state.
    always_comb begin
        nxt_rdata = 32'h0;
        nxt_rhit = 1'b1;
        if (hit(s_axi_araddr, `SGC_OFS_RUN_GATE)) begin
            nxt_rdata = run_gate_ff;
        end else if (hit(s_axi_araddr, `SGC_OFS_SLEEP_GATE)) begin
            nxt_rdata = sleep_gate_ff;
        end else if (hit(s_axi_araddr, `SGC_OFS_DEEP_GATE)) begin
            nxt_rdata = deep_gate_ff;
        end else if (hit(s_axi_araddr, `SGC_OFS_CLK_CFG)) begin
            nxt_rdata[`SGC_BIT_AUTO_GATE] = auto_gate_ff;
        end else if (hit(s_axi_araddr, `SGC_OFS_IRQ_STAT)) begin
            nxt_rdata[2:0] = irq_stat_ff;
        end else if (hit(s_axi_araddr, `SGC_OFS_IRQ_MASK)) begin
            nxt_rdata[2:0] = irq_mask_ff;
        end else if (hit(s_axi_araddr, `SGC_OFS_EFF_GATE)) begin
            nxt_rdata = eff_gate;
        end else begin
            nxt_rhit = 1'b0;
        end
    end

    // Read channel.
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `SGC_RESP_OKAY;
            rdata_ff <= 32'h0;
            raddr_ff <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= nxt_rhit ? `SGC_RESP_OKAY : `SGC_RESP_SLVERR;
            rdata_ff <= nxt_rdata;
            raddr_ff <= s_axi_araddr;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Effective word for the current mode.
    sgc_gate_select u_sel (
        .clk(clk),
        .rst(rst),
        .run_gate(run_gate_ff),
        .sleep_gate(sleep_gate_ff),
        .deep_gate(deep_gate_ff),
        .auto_gate(auto_gate_ff),
        .mode(power_mode),
        .eff_gate(eff_gate)
    );

    // Unit enables and rate code straight from the effective word.
    assign adc_clk_en = eff_gate[`SGC_BIT_ADC];
    assign hib_clk_en = eff_gate[`SGC_BIT_HIB];
    assign wdt_clk_en = eff_gate[`SGC_BIT_WDT];
    assign adc_rate_sel = eff_gate[`SGC_BIT_RATE_HI:`SGC_BIT_RATE_LO];
    assign unit_clk_en = {wdt_clk_en, hib_clk_en, adc_clk_en};

    // Fault pulses; they also feed the sticky status above.
    sgc_fault_check u_fault (
        .clk(clk),
        .rst(rst),
        .unit_access(unit_access),
        .unit_clk_en(unit_clk_en),
        .unit_fault(unit_fault)
    );

    property p_reset_value;
        @(posedge clk) rst |=> sleep_gate_ff == `SGC_GATE_RST && run_gate_ff == `SGC_GATE_RST;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("Gating reset value wrong.");

    property p_sleep_decode;
        @(posedge clk) disable iff (rst)
        wr_fire && hit(awaddr_ff, `SGC_OFS_SLEEP_GATE) && wstrb_ff == 4'hf
        |=> sleep_gate_ff == ($past(wdata_ff) & `SGC_GATE_WMASK);
    endproperty
    a_sleep_decode: assert property (p_sleep_decode) else $error("Sleep word write lost.");

    property p_run_decode;
        @(posedge clk) disable iff (rst)
        wr_fire && hit(awaddr_ff, `SGC_OFS_RUN_GATE) && wstrb_ff == 4'hf
        |=> run_gate_ff == ($past(wdata_ff) & `SGC_GATE_WMASK);
    endproperty
    a_run_decode: assert property (p_run_decode) else $error("Run word write lost.");

    property p_sleep_apply;
        @(posedge clk) disable iff (rst)
        auto_gate_ff && power_mode == sgc_pkg::SGC_MODE_SLEEP |=> hib_clk_en == $past(sleep_gate_ff[`SGC_BIT_HIB]);
    endproperty
    a_sleep_apply: assert property (p_sleep_apply) else $error("Sleep word not applied.");

    property p_sleep_rate;
        @(posedge clk) disable iff (rst)
        auto_gate_ff && power_mode == sgc_pkg::SGC_MODE_SLEEP
        |=> adc_rate_sel == $past(sleep_gate_ff[`SGC_BIT_RATE_HI:`SGC_BIT_RATE_LO]);
    endproperty
    a_sleep_rate: assert property (p_sleep_rate) else $error("Sleep rate code not applied.");

    property p_manual_gate;
        @(posedge clk) disable iff (rst)
        !auto_gate_ff |=> adc_clk_en == $past(run_gate_ff[`SGC_BIT_ADC])
            && adc_rate_sel == $past(run_gate_ff[`SGC_BIT_RATE_HI:`SGC_BIT_RATE_LO]);
    endproperty
    a_manual_gate: assert property (p_manual_gate) else $error("Sleep word acted without auto gating.");

    property p_adc_fault;
        @(posedge clk) disable iff (rst)
        unit_access[`SGC_UNIT_ADC] && !adc_clk_en |=> unit_fault[`SGC_UNIT_ADC] ##1 irq_stat_ff[`SGC_UNIT_ADC];
    endproperty
    a_adc_fault: assert property (p_adc_fault) else $error("Converter fault missing.");

    property p_wdt_fault;
        @(posedge clk) disable iff (rst)
        unit_access[`SGC_UNIT_WDT] |=> unit_fault[`SGC_UNIT_WDT] == !$past(wdt_clk_en);
    endproperty
    a_wdt_fault: assert property (p_wdt_fault) else $error("Watchdog fault wrong.");

    property p_hib_fault;
        @(posedge clk) disable iff (rst)
        unit_access[`SGC_UNIT_HIB] && hib_clk_en |=> !unit_fault[`SGC_UNIT_HIB];
    endproperty
    a_hib_fault: assert property (p_hib_fault) else $error("Fault on clocked unit.");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        rvalid_ff && hit(raddr_ff, `SGC_OFS_SLEEP_GATE) |-> (rdata_ff & ~`SGC_GATE_WMASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit reads one.");

    property p_irq_level;
        @(posedge clk) disable iff (rst)
        |(irq_stat_ff & irq_mask_ff) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised.");

    c_sleep_write: cover property (@(posedge clk) wr_fire && hit(awaddr_ff, `SGC_OFS_SLEEP_GATE));
    c_fault: cover property (@(posedge clk) |unit_fault);
    c_irq: cover property (@(posedge clk) irq);
    c_fast_rate: cover property (@(posedge clk) adc_rate_sel == 2'h1);
    c_deep: cover property (@(posedge clk) auto_gate_ff && power_mode == sgc_pkg::SGC_MODE_DEEP);
endmodule

// ===== shared/sgc_params.svh
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH
// Address decode.
`define SGC_BASE 32'h400fe000
`define SGC_OFS_RUN_GATE 12'h100
`define SGC_OFS_SLEEP_GATE 12'h110
`define SGC_OFS_DEEP_GATE 12'h120
`define SGC_OFS_CLK_CFG 12'h060
`define SGC_OFS_IRQ_STAT 12'h140
`define SGC_OFS_IRQ_MASK 12'h144
`define SGC_OFS_EFF_GATE 12'h148
// Gating word layout.
`define SGC_BIT_ADC 16
`define SGC_BIT_RATE_HI 9
`define SGC_BIT_RATE_LO 8
`define SGC_BIT_HIB 6
`define SGC_BIT_WDT 3
`define SGC_BIT_AUTO_GATE 27
`define SGC_GATE_WMASK 32'h00010348
`define SGC_GATE_RST 32'h00000040
`define SGC_CLK_CFG_RST 32'h00000000
`define SGC_IRQ_RST 3'h0
// Unit order in fault and interrupt vectors.
`define SGC_UNIT_ADC 0
`define SGC_UNIT_HIB 1
`define SGC_UNIT_WDT 2
`define SGC_NUM_UNITS 3
// Bus responses.
`define SGC_RESP_OKAY 2'h0
`define SGC_RESP_SLVERR 2'h2
`endif

// ===== shared/sgc_pkg.sv
package sgc_pkg;
    // Power mode reported by the power controller.
    typedef enum logic [1:0] {
        SGC_MODE_RUN = 2'h0,
        SGC_MODE_SLEEP = 2'h1,
        SGC_MODE_DEEP = 2'h2
    } sgc_mode_t;
    typedef logic [31:0] sgc_word_t;
endpackage

// ===== verification/tb_sleep_mode_clock_gating_0.sv
`timescale 1ns/1ps
`include "sgc_params.svh"
module tb_sleep_mode_clock_gating_0;
    logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_mode, adc_rate_sel, rsp;
    logic [2:0] unit_access, unit_fault;
    logic adc_clk_en, hib_clk_en, wdt_clk_en;
    logic [31:0] rd;
    int n_mismatch = 0;
    int n_checks = 0;

    sgc_top u_sgc_top (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .power_mode(power_mode), .unit_access(unit_access), .adc_clk_en(adc_clk_en), .hib_clk_en(hib_clk_en),
        .wdt_clk_en(wdt_clk_en), .adc_rate_sel(adc_rate_sel), .unit_fault(unit_fault), .irq(irq));

    // The 20 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_of_test;
        $display("Checks made: %0d, mismatches: %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Handshakes are judged at the falling edge so the rising edge only releases what was taken.
    task automatic wr(input logic [11:0] ofs, input logic [31:0] data, input logic [3:0] strb);
        logic aw_go, w_go, b_go;
        int n;
        b_go = 1'b0;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= `SGC_BASE + {20'h0, ofs};
        s_axi_wdata <= data;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_go && n < 100) begin
            @(negedge clk);
            aw_go = s_axi_awvalid && s_axi_awready;
            w_go = s_axi_wvalid && s_axi_wready;
            b_go = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (aw_go) s_axi_awvalid <= 1'b0;
            if (w_go) s_axi_wvalid <= 1'b0;
            if (b_go) s_axi_bready <= 1'b0;
            n++;
        end
        if (!b_go) chk(32'h1, 32'h0, "write response missing");
    endtask

    task automatic rdw(input logic [11:0] ofs);
        logic ar_go, r_go;
        int n;
        r_go = 1'b0;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= `SGC_BASE + {20'h0, ofs};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_go && n < 100) begin
            @(negedge clk);
            ar_go = s_axi_arvalid && s_axi_arready;
            r_go = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
            if (ar_go) s_axi_arvalid <= 1'b0;
            if (r_go) s_axi_rready <= 1'b0;
            n++;
        end
        if (!r_go) chk(32'h1, 32'h0, "read data missing");
    endtask

    // Reads a register and compares both the word and an OKAY response.
    task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp);
        rdw(ofs);
        chk(rd, exp, "register read");
        chk({30'h0, rsp}, 32'h0, "read response");
    endtask

    // Settle two edges, then compare enables and rate against what the gating word implies.
    task automatic en_chk(input logic [31:0] w);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({27'h0, adc_rate_sel, wdt_clk_en, hib_clk_en, adc_clk_en}, {27'h0, w[9:8], w[3], w[6], w[16]},
            "clock enables");
    endtask

    // One access pulse; fault one cycle after, status after two, irq after three.
    task automatic poke(input logic [2:0] acc, input logic [2:0] exp_fault, input logic exp_irq);
        @(posedge clk);
        unit_access <= acc;
        @(posedge clk);
        unit_access <= 3'h0;
        @(negedge clk);
        chk({29'h0, unit_fault}, {29'h0, exp_fault}, "fault pulse");
        @(negedge clk);
        chk({29'h0, unit_fault}, 32'h0, "fault pulse length");
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp_irq}, "interrupt level");
    endtask

    task automatic t_reset;
        rd_chk(12'h100, 32'h00000040);
        rd_chk(12'h110, 32'h00000040);
        rd_chk(12'h120, 32'h00000040);
        rd_chk(12'h060, 32'h0);
        en_chk(32'h00000040);
    endtask

    // Stopped converter and watchdog fault, the running hibernate unit does not.
    task automatic t_faults;
        wr(12'h144, 32'h7, 4'hf);
        poke(3'b001, 3'b001, 1'b1);
        rd_chk(12'h140, 32'h1);
        wr(12'h140, 32'h1, 4'hf);
        rd_chk(12'h140, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        poke(3'b010, 3'b000, 1'b0);
        poke(3'b100, 3'b100, 1'b1);
        wr(12'h144, 32'h0, 4'hf);
        poke(3'b001, 3'b001, 1'b0);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0, "masked irq");
        rd_chk(12'h140, 32'h5);
        wr(12'h140, 32'h5, 4'hf);
        rd_chk(12'h140, 32'h0);
    endtask

    // Reserved bits stay zero, byte strobes limit the write, the effective word is read-only.
    task automatic t_regs;
        wr(12'h100, 32'hfffffdff, 4'hf);
        rd_chk(12'h100, 32'h00010148);
        en_chk(32'h00010148);
        wr(12'h100, 32'h0, 4'h1);
        rd_chk(12'h100, 32'h00010100);
        en_chk(32'h00010100);
        rd_chk(12'h148, 32'h00010100);
        wr(12'h148, 32'h0, 4'hf);
        chk({30'h0, rsp}, 32'h0, "read-only write response");
        rd_chk(12'h148, 32'h00010100);
        wr(12'h144, 32'h7, 4'hf);
        poke(3'b111, 3'b110, 1'b1);
        wr(12'h140, 32'h7, 4'hf);
        wr(12'h110, 32'hfffffdff, 4'hf);
        rd_chk(12'h110, 32'h00010148);
        wr(12'h110, 32'h00000008, 4'hf);
        rd_chk(12'h110, 32'h00000008);
    endtask

    task automatic set_mode(input logic [1:0] m, input logic [31:0] w);
        @(posedge clk);
        power_mode <= m;
        en_chk(w);
    endtask

    // Sleep words only count once automatic gating is on; mode 3 counts as running.
    task automatic t_modes;
        set_mode(sgc_pkg::SGC_MODE_SLEEP, 32'h00010100);
        wr(12'h060, 32'hffffffff, 4'hf);
        rd_chk(12'h060, 32'h08000000);
        en_chk(32'h00000008);
        set_mode(sgc_pkg::SGC_MODE_DEEP, 32'h00000040);
        set_mode(2'h3, 32'h00010100);
        set_mode(sgc_pkg::SGC_MODE_RUN, 32'h00010100);
        wr(12'h060, 32'h0, 4'hf);
        set_mode(sgc_pkg::SGC_MODE_SLEEP, 32'h00010100);
    endtask

    task automatic t_unmapped;
        rdw(12'h004);
        chk({30'h0, rsp}, 32'h2, "unmapped read response");
        chk(rd, 32'h0, "unmapped read data");
        wr(12'h200, 32'hffffffff, 4'hf);
        chk({30'h0, rsp}, 32'h2, "unmapped write response");
        rd_chk(12'h100, 32'h00010100);
    endtask

    // A hang is cut short well past the expected length of the run.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        s_axi_awaddr = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 32'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        power_mode = 2'h0;
        unit_access = 3'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_faults();
        t_regs();
        t_modes();
        t_unmapped();
        end_of_test();
    end
endmodule
